// file: design/port_regs_pkg.sv
// Package for the per-port status and control register pair of a power sourcing port.
// Assumes one 40 MHz clock and a plain address/strobe register port with 16-bit data.
package port_regs_pkg;

  // Register offsets on the register port.
  localparam logic [3:0]  STATUS_OFFSET  = 4'h2;
  localparam logic [3:0]  CONTROL_OFFSET = 4'h3;

  // Status word field positions.
  localparam int unsigned ST_DET_OVER    = 13;
  localparam int unsigned ST_DET_UNDER   = 12;
  localparam int unsigned ST_HS_PGOOD    = 11;
  localparam int unsigned ST_LS_PGOOD    = 10;
  localparam int unsigned ST_FULL_V      = 9;
  localparam int unsigned ST_OVERLOAD    = 8;
  localparam int unsigned ST_SLEEP       = 7;
  localparam int unsigned ST_IDLE        = 6;
  localparam int unsigned ST_DETECT      = 5;
  localparam int unsigned ST_POWERED     = 4;
  localparam int unsigned ST_SETTLE      = 3;

  // Control word field positions.
  localparam int unsigned CT_FORCED_UP   = 15;
  localparam int unsigned CT_END_CLASS   = 14;
  localparam int unsigned CT_CLASS_MODE  = 13;
  localparam int unsigned CT_PULLUP_OFF  = 12;
  localparam int unsigned CT_DET_TMR_OFF = 11;
  localparam int unsigned CT_FOLDBK_OFF  = 10;
  localparam int unsigned CT_SOFTST_OFF  = 9;
  localparam int unsigned CT_DISCH_OFF   = 8;
  localparam int unsigned CT_SIGDO_OFF   = 7;
  localparam int unsigned CT_DET_READY   = 6;
  localparam int unsigned CT_SUPPLY_OK   = 5;
  localparam int unsigned CT_DEV_WAKE_BK = 4;
  localparam int unsigned CT_SRC_WAKE_BK = 3;
  localparam int unsigned CT_WAKE_CMD    = 2;
  localparam int unsigned CT_PIN_GATE    = 1;
  localparam int unsigned CT_ENABLE      = 0;

  // Values after reset; the enable pin is left in effect.
  localparam logic [15:0] CONTROL_RESET  = 16'h0002;
  localparam logic [15:0] STATUS_RESET   = 16'h0000;

  // Port state codes.
  localparam logic [2:0]  CODE_DISABLED  = 3'h0;
  localparam logic [2:0]  CODE_SLEEPING  = 3'h1;
  localparam logic [2:0]  CODE_POWERING  = 3'h2;
  localparam logic [2:0]  CODE_SEARCHING = 3'h3;
  localparam logic [2:0]  CODE_ERROR     = 3'h4;
  localparam logic [2:0]  CODE_IDLE      = 3'h5;
  localparam logic [2:0]  CODE_PREP_DET  = 3'h6;
  localparam logic [2:0]  CODE_UNKNOWN   = 3'h7;

  // States reported by the port state machine that sits outside this block.
  typedef enum logic [3:0] {
    PH_DISABLED,
    PH_PREP_DETECT,
    PH_IDLE,
    PH_DETECTION,
    PH_POWER_UP,
    PH_POWER_ON,
    PH_OVERLOAD,
    PH_SETTLE_SLEEP,
    PH_SLEEP,
    PH_ERROR,
    PH_UNKNOWN
  } port_phase_t;

  // Analog comparator results fed in by the port front end.
  typedef struct packed {
    logic det_over;
    logic det_under;
    logic hs_pgood;
    logic ls_pgood;
  } comparators_t;

  // Controls handed to the port state machine and the analog front end.
  typedef struct packed {
    logic forced_power_up;
    logic end_class;
    logic class_mode;
    logic pullup_off;
    logic detect_timer_off;
    logic foldback_off;
    logic soft_start_off;
    logic discharge_timer_off;
    logic signature_dropout_timer_off;
    logic port_detect_ready;
    logic port_supply_ok;
    logic port_enable;
    logic device_wake_go;
    logic source_wake_go;
  } port_controls_t;

  // Whole register state of the block.
  typedef struct packed {
    logic [15:0]    status;
    logic [15:0]    control;
    logic [15:0]    rdata;
    port_controls_t ctl;
  } regs_state_t;

endpackage : port_regs_pkg

// file: design/port_status_config_regs.sv
// Per-port status and control register pair with its derived control outputs.
// Assumes the port state machine and comparators outside supply synchronous inputs.
`timescale 1ns/1ps
`default_nettype none

module port_status_config_regs
  import port_regs_pkg::*;
#(
  parameter int unsigned ADDR_W = 4
)(
  input  wire logic              SYS_CLK,
  input  wire logic              RST_B,
  input  wire logic              CLK_EN,
  input  wire logic [ADDR_W-1:0] ADDR,
  input  wire logic [15:0]       WDATA,
  input  wire logic              WR_STB,
  input  wire logic              RD_STB,
  output logic [15:0]            RDATA,
  input  wire port_phase_t       PORT_PHASE,
  input  wire comparators_t      COMPARE,
  input  wire logic              EN_PIN,
  input  wire logic              DEVICE_WAKE_IN,
  input  wire logic              SOURCE_WAKE_IN,
  output port_controls_t         CONTROLS
);

  // The offsets must fit in the address port.
  if (ADDR_W < 2) begin : g_bad_addr
    $error("ADDR_W too narrow for the register offsets.");
  end

  regs_state_t st_r;
  regs_state_t st_nxt;
  logic        wr_ctl;
  logic        rd_hit;
  logic [15:0] ctl_next;

  // Maps the port phase to its three-bit state code.
  function automatic logic [2:0] phase_code(input port_phase_t ph);
    logic [2:0] c;
    c = CODE_UNKNOWN;
    case (ph)
      PH_DISABLED:                 c = CODE_DISABLED;
      PH_SETTLE_SLEEP, PH_SLEEP:   c = CODE_SLEEPING;
      PH_POWER_UP, PH_POWER_ON:    c = CODE_POWERING;
      PH_DETECTION:                c = CODE_SEARCHING;
      PH_OVERLOAD, PH_ERROR:       c = CODE_ERROR;
      PH_IDLE:                     c = CODE_IDLE;
      PH_PREP_DETECT:              c = CODE_PREP_DET;
      default:                     c = CODE_UNKNOWN;
    endcase
    return c;
  endfunction : phase_code

  // Builds the status word from the phase and comparators.
  function automatic logic [15:0] status_word(input port_phase_t ph, input comparators_t cmp);
    logic [15:0] s;
    logic        det;
    logic        full;
    s    = 16'h0000; // Reserved bits 15:14 stay zero.
    det  = (ph == PH_DETECTION);
    full = (ph == PH_POWER_ON);
    s[ST_DET_OVER]  = det & cmp.det_over;
    s[ST_DET_UNDER] = det & cmp.det_under;
    s[ST_HS_PGOOD]  = full & cmp.hs_pgood;
    s[ST_LS_PGOOD]  = full & cmp.ls_pgood;
    s[ST_FULL_V]    = full;
    s[ST_OVERLOAD]  = (ph == PH_OVERLOAD);
    s[ST_SLEEP]     = (ph == PH_SETTLE_SLEEP) | (ph == PH_SLEEP);
    s[ST_IDLE]      = (ph == PH_IDLE);
    s[ST_DETECT]    = det;
    s[ST_POWERED]   = (ph == PH_POWER_UP) | full;
    s[ST_SETTLE]    = (ph == PH_SETTLE_SLEEP);
    s[2:0]          = phase_code(ph);
    return s;
  endfunction : status_word

  // Address decode; writes to the status offset are simply dropped.
  assign wr_ctl = WR_STB & (ADDR == ADDR_W'(CONTROL_OFFSET));
  assign rd_hit = RD_STB;

  // Next control word: the end-classification bit clears itself one cycle after
  // it was set, but a fresh write of one in that same cycle wins over the clear.
  always_comb
  begin
    ctl_next = st_r.control;
    ctl_next[CT_END_CLASS] = 1'b0;
    if (wr_ctl)
    begin
      ctl_next = WDATA;
    end
  end

  // Next state of the whole block.
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.status  = status_word(PORT_PHASE, COMPARE);
    st_nxt.control = ctl_next;
    if (rd_hit)
    begin
      if (ADDR == ADDR_W'(STATUS_OFFSET))
      begin
        st_nxt.rdata = st_r.status;
      end
      else if (ADDR == ADDR_W'(CONTROL_OFFSET))
      begin
        st_nxt.rdata = st_r.control;
      end
      else
      begin
        st_nxt.rdata = 16'h0000; // Unmapped addresses read as zero.
      end
    end
    // Controls follow the stored word one cycle after it is written.
    st_nxt.ctl.forced_power_up             = st_r.control[CT_FORCED_UP];
    st_nxt.ctl.end_class                   = st_r.control[CT_END_CLASS];
    st_nxt.ctl.class_mode                  = st_r.control[CT_CLASS_MODE];
    st_nxt.ctl.pullup_off                  = st_r.control[CT_PULLUP_OFF];
    st_nxt.ctl.detect_timer_off            = st_r.control[CT_DET_TMR_OFF];
    // Foldback and soft-start are only relevant during inrush in power-up.
    st_nxt.ctl.foldback_off   = st_r.control[CT_FOLDBK_OFF] & (PORT_PHASE == PH_POWER_UP);
    st_nxt.ctl.soft_start_off = st_r.control[CT_SOFTST_OFF] & (PORT_PHASE == PH_POWER_UP);
    st_nxt.ctl.discharge_timer_off         = st_r.control[CT_DISCH_OFF];
    st_nxt.ctl.signature_dropout_timer_off = st_r.control[CT_SIGDO_OFF];
    st_nxt.ctl.port_detect_ready           = st_r.control[CT_DET_READY];
    st_nxt.ctl.port_supply_ok              = st_r.control[CT_SUPPLY_OK];
    // With the gate bit at zero the pin has no say in enabling the port.
    st_nxt.ctl.port_enable = st_r.control[CT_ENABLE]
                           | (st_r.control[CT_PIN_GATE] & EN_PIN);
    st_nxt.ctl.device_wake_go = DEVICE_WAKE_IN & ~st_r.control[CT_DEV_WAKE_BK];
    // A host wake command is a source-side wake, so the source block gates it too.
    st_nxt.ctl.source_wake_go = (SOURCE_WAKE_IN | st_r.control[CT_WAKE_CMD])
                              & ~st_r.control[CT_SRC_WAKE_BK];
  end

  // Single state register, frozen while the clock enable is low.
  always_ff @(posedge SYS_CLK)
  begin
    if (!RST_B)
    begin
      st_r.status  <= STATUS_RESET;
      st_r.control <= CONTROL_RESET;
      st_r.rdata   <= 16'h0000;
      st_r.ctl     <= '0;
    end
    else if (CLK_EN)
    begin
      st_r <= st_nxt;
    end
  end

  assign RDATA    = st_r.rdata;
  assign CONTROLS = st_r.ctl;

  // Helper: phase and comparators one enabled cycle back.
  port_phase_t  ph_d;
  comparators_t cmp_d;
  always_ff @(posedge SYS_CLK)
  begin
    if (CLK_EN)
    begin
      ph_d  <= PORT_PHASE;
      cmp_d <= COMPARE;
    end
  end

  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RST_B);

  a_det_flags: assert property ($past(RST_B) && $past(CLK_EN) ##0 1 |->
    st_r.status[ST_DET_OVER] == (ph_d == PH_DETECTION && cmp_d.det_over)
    && st_r.status[ST_DET_UNDER] == (ph_d == PH_DETECTION && cmp_d.det_under))
    else $error("Detection voltage flags wrong.");

  a_pgood_flags: assert property ($past(RST_B) && $past(CLK_EN) |->
    st_r.status[ST_HS_PGOOD] == (ph_d == PH_POWER_ON && cmp_d.hs_pgood)
    && st_r.status[ST_LS_PGOOD] == (ph_d == PH_POWER_ON && cmp_d.ls_pgood))
    else $error("Power-good flags wrong.");

  a_full_voltage: assert property ($past(RST_B) && $past(CLK_EN) |->
    st_r.status[ST_FULL_V] == (ph_d == PH_POWER_ON))
    else $error("Full voltage flag wrong.");

  a_overload_flag: assert property ($past(RST_B) && $past(CLK_EN) |->
    st_r.status[ST_OVERLOAD] == (ph_d == PH_OVERLOAD))
    else $error("Overload flag wrong.");

  a_phase_flags: assert property ($past(RST_B) && $past(CLK_EN) |->
    st_r.status[ST_SLEEP] == (ph_d == PH_SLEEP || ph_d == PH_SETTLE_SLEEP)
    && st_r.status[ST_IDLE] == (ph_d == PH_IDLE)
    && st_r.status[ST_DETECT] == (ph_d == PH_DETECTION)
    && st_r.status[ST_POWERED] == (ph_d == PH_POWER_UP || ph_d == PH_POWER_ON)
    && st_r.status[ST_SETTLE] == (ph_d == PH_SETTLE_SLEEP))
    else $error("Port phase flags wrong.");

  a_state_code: assert property ($past(RST_B) && $past(CLK_EN) && ph_d == PH_POWER_ON |->
    st_r.status[2:0] == 3'h2 && st_r.status[15:14] == 2'h0)
    else $error("State code for power-on wrong.");

  a_end_class_clear: assert property (CLK_EN && st_r.control[CT_END_CLASS] && !wr_ctl |=>
    !st_r.control[CT_END_CLASS])
    else $error("End-classification bit did not self-clear.");

  a_end_class_out: assert property (CLK_EN && st_r.control[CT_END_CLASS] |=>
    CONTROLS.end_class)
    else $error("End-classification output missing.");

  a_status_ro: assert property (CLK_EN && WR_STB && ADDR == ADDR_W'(STATUS_OFFSET) |=>
    st_r.control == $past(st_r.control) || $past(st_r.control[CT_END_CLASS]))
    else $error("Status write disturbed the control word.");

  a_enable_mask: assert property (CLK_EN && !st_r.control[CT_PIN_GATE] |=>
    CONTROLS.port_enable == $past(st_r.control[CT_ENABLE]))
    else $error("Masked enable pin still acted.");

  a_wake_block: assert property (CLK_EN && st_r.control[CT_SRC_WAKE_BK] |=>
    !CONTROLS.source_wake_go)
    else $error("Source wake not suppressed.");

  a_read_data: assert property (CLK_EN && RD_STB && ADDR == ADDR_W'(CONTROL_OFFSET) |=>
    RDATA == $past(st_r.control))
    else $error("Control readback wrong.");

  // Each phase flag on its own, so a failure names the bit at fault.
  a_idle_flag: assert property (
    $past(RST_B) && $past(CLK_EN) |->
    st_r.status[ST_IDLE] == (ph_d == PH_IDLE))
    else $error("Idle flag wrong.");

  a_detect_flag: assert property (
    $past(RST_B) && $past(CLK_EN) |->
    st_r.status[ST_DETECT] == (ph_d == PH_DETECTION))
    else $error("Detection flag wrong.");

  a_powered_flag: assert property (
    $past(RST_B) && $past(CLK_EN) |->
    st_r.status[ST_POWERED]
      == (ph_d == PH_POWER_UP || ph_d == PH_POWER_ON))
    else $error("Powered flag wrong.");

  a_settle_flag: assert property (
    $past(RST_B) && $past(CLK_EN) |->
    st_r.status[ST_SETTLE] == (ph_d == PH_SETTLE_SLEEP))
    else $error("Settle-sleep flag wrong.");

  a_sleep_flag: assert property (
    $past(RST_B) && $past(CLK_EN) |->
    st_r.status[ST_SLEEP]
      == (ph_d == PH_SETTLE_SLEEP || ph_d == PH_SLEEP))
    else $error("Sleep flag wrong.");

  // The state code, one phase group at a time.
  a_code_disabled: assert property (
    $past(RST_B) && $past(CLK_EN) && ph_d == PH_DISABLED |->
    st_r.status[2:0] == 3'h0)
    else $error("State code for disabled wrong.");

  a_code_sleep: assert property (
    $past(RST_B) && $past(CLK_EN)
      && (ph_d == PH_SETTLE_SLEEP || ph_d == PH_SLEEP) |->
    st_r.status[2:0] == 3'h1)
    else $error("State code for sleep wrong.");

  a_code_search: assert property (
    $past(RST_B) && $past(CLK_EN) && ph_d == PH_DETECTION |->
    st_r.status[2:0] == 3'h3)
    else $error("State code for detection wrong.");

  a_code_error: assert property (
    $past(RST_B) && $past(CLK_EN)
      && (ph_d == PH_OVERLOAD || ph_d == PH_ERROR) |->
    st_r.status[2:0] == 3'h4)
    else $error("State code for error wrong.");

  a_code_idle: assert property (
    $past(RST_B) && $past(CLK_EN) && ph_d == PH_IDLE |->
    st_r.status[2:0] == 3'h5)
    else $error("State code for idle wrong.");

  a_code_prep: assert property (
    $past(RST_B) && $past(CLK_EN) && ph_d == PH_PREP_DETECT |->
    st_r.status[2:0] == 3'h6)
    else $error("State code for prepare wrong.");

  a_code_unknown: assert property (
    $past(RST_B) && $past(CLK_EN) && ph_d == PH_UNKNOWN |->
    st_r.status[2:0] == 3'h7)
    else $error("State code for unknown wrong.");

  // Reserved bits hold zero in every cycle outside reset.
  a_reserved_zero: assert property (
    st_r.status[15:14] == 2'h0)
    else $error("Reserved status bits set.");

  // Plain control levels follow the stored word one enabled cycle later.
  a_forced_up: assert property (
    CLK_EN |=>
    CONTROLS.forced_power_up == $past(st_r.control[CT_FORCED_UP]))
    else $error("Forced power-up output wrong.");

  a_class_mode: assert property (
    CLK_EN |=>
    CONTROLS.class_mode == $past(st_r.control[CT_CLASS_MODE]))
    else $error("Classification mode output wrong.");

  a_pullup_off: assert property (
    CLK_EN |=>
    CONTROLS.pullup_off == $past(st_r.control[CT_PULLUP_OFF]))
    else $error("Pull-up disable output wrong.");

  a_det_timer: assert property (
    CLK_EN |=>
    CONTROLS.detect_timer_off == $past(st_r.control[CT_DET_TMR_OFF]))
    else $error("Detection timer output wrong.");

  // The inrush controls must never leak outside the power-up phase.
  a_foldback: assert property (
    CLK_EN |=> CONTROLS.foldback_off
      == $past(st_r.control[CT_FOLDBK_OFF] && PORT_PHASE == PH_POWER_UP))
    else $error("Foldback output wrong.");

  a_soft_start: assert property (
    CLK_EN |=> CONTROLS.soft_start_off
      == $past(st_r.control[CT_SOFTST_OFF] && PORT_PHASE == PH_POWER_UP))
    else $error("Soft-start output wrong.");

  a_discharge: assert property (
    CLK_EN |=>
    CONTROLS.discharge_timer_off == $past(st_r.control[CT_DISCH_OFF]))
    else $error("Discharge timer output wrong.");

  a_sig_dropout: assert property (
    CLK_EN |=> CONTROLS.signature_dropout_timer_off
      == $past(st_r.control[CT_SIGDO_OFF]))
    else $error("Dropout timer output wrong.");

  a_dev_wake: assert property (
    CLK_EN |=> CONTROLS.device_wake_go
      == $past(DEVICE_WAKE_IN && !st_r.control[CT_DEV_WAKE_BK]))
    else $error("Device wake gating wrong.");

  a_host_wake: assert property (
    CLK_EN && st_r.control[CT_WAKE_CMD]
      && !st_r.control[CT_SRC_WAKE_BK] |=>
    CONTROLS.source_wake_go)
    else $error("Host wake command lost.");

  a_port_enable: assert property (
    CLK_EN && st_r.control[CT_ENABLE] |=>
    CONTROLS.port_enable)
    else $error("Host enable did not enable the port.");

  // A taken write lands whole in the control word.
  a_ctl_write: assert property (
    CLK_EN && wr_ctl |=>
    st_r.control == $past(WDATA))
    else $error("Control write did not land.");

  a_status_read: assert property (
    CLK_EN && RD_STB && ADDR == ADDR_W'(STATUS_OFFSET) |=>
    RDATA == $past(st_r.status))
    else $error("Status readback wrong.");

  // With the enable low nothing may move, not even the read data.
  a_freeze: assert property (
    !CLK_EN |=> st_r == $past(st_r))
    else $error("State moved while frozen.");

  c_frozen_write: cover property (!CLK_EN && WR_STB);
  c_host_wake: cover property (CLK_EN && st_r.control[CT_WAKE_CMD] ##1 CONTROLS.source_wake_go);
  c_write_read: cover property (CLK_EN && wr_ctl ##1 CLK_EN && RD_STB);
  c_power_on: cover property (st_r.status[ST_FULL_V] && CONTROLS.port_enable);
  c_end_class: cover property (CLK_EN && wr_ctl && WDATA[CT_END_CLASS] ##2 CONTROLS.end_class);

endmodule : port_status_config_regs

`default_nettype wire

// file: testbench/host_bus_model.sv
// Host side of the register port: single-cycle write and read tasks.
// Assumes one clock; read data appear in the cycle after the read strobe and hold until the next read.
`timescale 1ns/1ps
`default_nettype none

module host_bus_model (
  input  wire logic        SYS_CLK,
  output logic [3:0]       ADDR,
  output logic [15:0]      WDATA,
  output logic             WR_STB,
  output logic             RD_STB,
  input  wire logic [15:0] RDATA
);
  // Quiet bus at time zero.
  initial
  begin
    ADDR   = 4'h0;
    WDATA  = 16'h0000;
    WR_STB = 1'b0;
    RD_STB = 1'b0;
  end

  // Data are inverted after a write so a stale word is never mistaken for a fresh one.
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge SYS_CLK);
    ADDR   <= a;
    WDATA  <= d;
    WR_STB <= 1'b1;
    @(posedge SYS_CLK);
    WR_STB <= 1'b0;
    WDATA  <= ~d;
  endtask : wr

  // The word is taken in the one cycle after the read edge, once it has settled.
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge SYS_CLK);
    ADDR   <= a;
    RD_STB <= 1'b1;
    @(posedge SYS_CLK);
    RD_STB <= 1'b0;
    #1;
    d = RDATA;
  endtask : rd
endmodule : host_bus_model
`default_nettype wire

// file: testbench/tb.sv
// Self-checking bench for the port status and control register pair.
// Assumes the host model drives the register port; the bench drives phase and pins.
`timescale 1ns/1ps
`default_nettype none

module tb;
  import port_regs_pkg::*;
  logic           SYS_CLK, RST_B, CLK_EN, EN_PIN, DEVICE_WAKE_IN, SOURCE_WAKE_IN;
  logic [3:0]     ADDR;
  logic [15:0]    WDATA, RDATA, rv, w, n;
  logic           WR_STB, RD_STB;
  port_phase_t    PORT_PHASE;
  comparators_t   COMPARE;
  port_controls_t CONTROLS;
  int             error_cnt = 0;
  int             check_count = 0;
  int             cyc = 0;
  logic [15:0]    vals [3] = '{16'hA5A5, 16'h5A5A, 16'h0061};

  port_status_config_regs #(.ADDR_W(4)) i_dut (.SYS_CLK(SYS_CLK), .RST_B(RST_B),
    .CLK_EN(CLK_EN), .ADDR(ADDR), .WDATA(WDATA), .WR_STB(WR_STB), .RD_STB(RD_STB),
    .RDATA(RDATA), .PORT_PHASE(PORT_PHASE), .COMPARE(COMPARE), .EN_PIN(EN_PIN),
    .DEVICE_WAKE_IN(DEVICE_WAKE_IN), .SOURCE_WAKE_IN(SOURCE_WAKE_IN), .CONTROLS(CONTROLS));
  host_bus_model i_host (.SYS_CLK(SYS_CLK), .ADDR(ADDR), .WDATA(WDATA), .WR_STB(WR_STB),
    .RD_STB(RD_STB), .RDATA(RDATA));

  // Expected status word worked out from the port phase and comparators.
  function automatic logic [15:0] exp_st(port_phase_t p, comparators_t c);
    logic [15:0] s;
    s = 16'h0000;
    s[13] = c.det_over && p == PH_DETECTION;
    s[12] = c.det_under && p == PH_DETECTION;
    s[11] = c.hs_pgood && p == PH_POWER_ON;
    s[10] = c.ls_pgood && p == PH_POWER_ON;
    s[9] = p == PH_POWER_ON;
    s[8] = p == PH_OVERLOAD;
    s[7] = p inside {PH_SETTLE_SLEEP, PH_SLEEP};
    s[6] = p == PH_IDLE;
    s[5] = p == PH_DETECTION;
    s[4] = p inside {PH_POWER_UP, PH_POWER_ON};
    s[3] = p == PH_SETTLE_SLEEP;
    case (p)
      PH_DISABLED:               s[2:0] = 3'h0;
      PH_SETTLE_SLEEP, PH_SLEEP: s[2:0] = 3'h1;
      PH_POWER_UP, PH_POWER_ON:  s[2:0] = 3'h2;
      PH_DETECTION:              s[2:0] = 3'h3;
      PH_OVERLOAD, PH_ERROR:     s[2:0] = 3'h4;
      PH_IDLE:                   s[2:0] = 3'h5;
      PH_PREP_DETECT:            s[2:0] = 3'h6;
      default:                   s[2:0] = 3'h7;
    endcase
    return s;
  endfunction : exp_st

  // Expected control outputs once the end-of-class pulse has passed.
  function automatic logic [15:0] exp_ctl(logic [15:0] v, port_phase_t p, logic en, dw, sw);
    port_controls_t c;
    c = '{v[15], 1'b0, v[13], v[12], v[11], v[10] && p == PH_POWER_UP, v[9] && p == PH_POWER_UP,
          v[8], v[7], v[6], v[5], v[0] || (v[1] && en), dw && !v[4], (sw || v[2]) && !v[3]};
    return 16'(c);
  endfunction : exp_ctl

  // One comparison, counted; a mismatch is reported at once.
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
    check_count++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("mismatch at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk

  task automatic cycles(input int k);
    repeat (k) @(posedge SYS_CLK);
    #1;
  endtask : cycles

  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : stop_test

  // 40 MHz clock.
  initial
  begin
    SYS_CLK = 1'b0;
    forever #12.5 SYS_CLK = ~SYS_CLK;
  end

  // The tests need about five hundred cycles, so a hang is cut off well past that.
  always @(posedge SYS_CLK)
  begin
    cyc <= cyc + 1;
    if (cyc == 6000)
    begin
      error_cnt++;
      stop_test();
    end
  end

  // Main sequence.
  initial
  begin
    RST_B = 1'b0;
    CLK_EN = 1'b1;
    EN_PIN = 1'b0;
    DEVICE_WAKE_IN = 1'b0;
    SOURCE_WAKE_IN = 1'b0;
    PORT_PHASE = PH_DISABLED;
    COMPARE = '0;
    repeat (8) @(posedge SYS_CLK);
    RST_B <= 1'b1;
    cycles(1);
    chk(RDATA, 16'h0000, "rdata after reset");
    i_host.rd(4'h3, rv);
    chk(rv, 16'h0002, "control after reset");
    i_host.rd(4'h2, rv);
    chk(rv, 16'h0000, "status after reset");
    $display("test reset done");
    // Every phase under two complementary comparator patterns.
    for (int i = 0; i < 22; i++)
    begin
      @(posedge SYS_CLK);
      PORT_PHASE <= port_phase_t'(i % 11);
      COMPARE <= (i < 11) ? 4'hA : 4'h5;
      cycles(2);
      i_host.rd(4'h2, rv);
      chk(rv, exp_st(PORT_PHASE, COMPARE), "status");
    end
    i_host.wr(4'h2, 16'hFFFF);
    i_host.wr(4'h7, 16'hFFFF);
    i_host.rd(4'h3, rv);
    chk(rv, 16'h0002, "stray write");
    i_host.rd(4'h7, rv);
    chk(rv, 16'h0000, "unmapped read");
    i_host.rd(4'h2, rv);
    chk(rv, exp_st(PORT_PHASE, COMPARE), "status after write");
    $display("test status done");
    @(posedge SYS_CLK);
    PORT_PHASE <= PH_POWER_UP;
    // Whole-word values; the last one is the host announcing readiness and supply.
    foreach (vals[k])
    begin
      i_host.wr(4'h3, vals[k]);
      i_host.rd(4'h3, rv);
      chk(rv, vals[k] & 16'hBFFF, "control readback");
      w = exp_ctl(vals[k], PORT_PHASE, EN_PIN, DEVICE_WAKE_IN, SOURCE_WAKE_IN);
      chk(16'(CONTROLS), w, "controls");
    end
    // Wake, enable and inrush bits against the pins and phase.
    for (int i = 0; i < 64; i++)
    begin
      @(posedge SYS_CLK);
      PORT_PHASE <= i[5] ? PH_POWER_UP : PH_IDLE;
      EN_PIN <= i[5];
      DEVICE_WAKE_IN <= i[2] ^ i[5];
      SOURCE_WAKE_IN <= i[0] ^ i[4];
      w = {5'h00, i[1:0], 4'h0, i[4:0]};
      i_host.wr(4'h3, w);
      cycles(2);
      w = exp_ctl(w, PORT_PHASE, EN_PIN, DEVICE_WAKE_IN, SOURCE_WAKE_IN);
      chk(16'(CONTROLS), w, "gating");
    end
    $display("test control done");
    i_host.wr(4'h3, 16'h4000);
    n = 16'h0000;
    repeat (6)
    begin
      @(posedge SYS_CLK);
      #1;
      n = n + 16'(CONTROLS.end_class);
    end
    chk(n, 16'h0001, "end class pulse");
    @(posedge SYS_CLK);
    CLK_EN <= 1'b0;
    i_host.wr(4'h3, 16'hFFFF);
    @(posedge SYS_CLK);
    CLK_EN <= 1'b1;
    i_host.rd(4'h3, rv);
    chk(rv, 16'h0000, "write while frozen");
    i_host.wr(4'h3, 16'h0001);
    @(posedge SYS_CLK);
    RST_B <= 1'b0;
    @(posedge SYS_CLK);
    RST_B <= 1'b1;
    i_host.rd(4'h3, rv);
    chk(rv, 16'h0002, "control after second reset");
    $display("test pulse and reset done");
    stop_test();
  end
endmodule : tb
`default_nettype wire
